// [src/tws_pkg.sv]
// Purpose: Shared constants and types for the two-wire serial slave protocol block.
// Assumes: One 10 MHz system clock samples both bus lines.
// Notes: The device type identifier is the fixed upper nibble of a matching address byte.
package tws_pkg;

  localparam int CLK_MHZ = 10;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;

  // Settle time the master waits after supply is stable; the device does not time it.
  localparam int POWER_UP_SETTLE_TIME_US = 100;
  localparam int POWER_UP_SETTLE_CYC = POWER_UP_SETTLE_TIME_US * CLK_MHZ;

  localparam int BYTE_W = 8;
  localparam int SEL_W = 3;
  localparam int CNT_W = 4;
  localparam int PIN_W = 3 + SEL_W;

  localparam logic [CNT_W-1:0] BIT_LAST = 4'h7;
  localparam logic [CNT_W-1:0] BIT_ACK = 4'h8;

  localparam logic [3:0] DEV_TYPE_ID = 4'ha;
  localparam int ID_MSB = 7;
  localparam int ID_LSB = 4;
  localparam int SEL_MSB = 3;
  localparam int SEL_LSB = 1;
  localparam int RNW_BIT = 0;

  localparam logic [BYTE_W-1:0] TX_IDLE_BYTE = 8'hff;
  localparam int RX_DEPTH = 2;

  // Lines idle high, supply not yet good, select straps low.
  localparam logic [PIN_W-1:0] PINS_RST = 6'h30;

  typedef enum logic [2:0] {
    PH_POR,
    PH_IDLE,
    PH_ADDR,
    PH_WRITE,
    PH_READ,
    PH_IGNORE
  } tws_phase_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic por_ok;
    logic [SEL_W-1:0] sel;
  } tws_pins_t;

  typedef struct packed {
    logic [BYTE_W-1:0] data;
    logic valid;
  } tws_byte_t;

endpackage : tws_pkg

// [src/tws_pin_filter.sv]
// Purpose: Brings asynchronous pins into the clock domain and filters them.
// Assumes: Inputs may change at any time relative to clk.
// Notes: A new level is taken only when the second and third stages agree.
`timescale 1ns/1ps
module tws_pin_filter #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  clk,
  rst_n,
  pin_i,
  level_o
);
  import tws_pkg::*;

  input wire logic clk;
  input wire logic rst_n;
  input wire logic [W-1:0] pin_i;
  output logic [W-1:0] level_o;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } tws_filt_t;

  tws_filt_t s_q;
  tws_filt_t s_d;

  ////////////////////////////////////////////////////////////////////////////////
  // The first stage feeds only the second, so metastability never reaches logic.
  always_comb begin
    s_d = s_q;
    s_d.s1 = pin_i;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < W; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.lvl[i] = s_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.lvl;

endmodule : tws_pin_filter

// [src/tws_fifo.sv]
// Purpose: Small buffer with valid and ready on both sides.
// Assumes: DEPTH is a power of two, two or more.
// Notes: in_ready falls when full, so the writer must hold or refuse its word.
`timescale 1ns/1ps
module tws_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  clk,
  rst_n,
  in_valid,
  in_ready,
  in_data,
  out_valid,
  out_ready,
  out_data
);
  import tws_pkg::*;

  localparam int AW = $clog2(DEPTH);

  input wire logic clk;
  input wire logic rst_n;
  input wire logic in_valid;
  output logic in_ready;
  input wire logic [W-1:0] in_data;
  output logic out_valid;
  input wire logic out_ready;
  output logic [W-1:0] out_data;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } tws_fifo_t;

  tws_fifo_t s_q;
  tws_fifo_t s_d;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////////////
  assign in_ready = (s_q.cnt != DEPTH[AW:0]);
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : tws_fifo

// [src/tws_slave.sv]
// Purpose: Protocol layer of a two-wire serial EEPROM slave interface.
// Assumes: Bus lines are sampled by clk, far faster than the serial clock.
// Notes: Memory array, word addressing and write-cycle timing live outside.
//
// What this block does
// - Ignore the bus until supply passes threshold.
// - Sample on rising clock, drive on falling.
// - Bytes MSB first, ninth clock carries acknowledge.
// - Falling data with clock high is Start.
// - Rising data with clock high is Stop.
// - Repeated Start begins a new command.
// - No limit on bytes per transfer.
// - Bus idle only with both lines high.
// - Transmitter releases after eighth clock; receiver acknowledges.
// - Receiver releases data at end of ninth.
// - Master high on ninth ends read data.
// - Standby after power-up, plain Stop, write end.
// - Dummy clocks release data line for recovery.
// - Data line is open drain only.
// - Acknowledge only a matching address byte.
// - No address acknowledge during write cycle.
`timescale 1ns/1ps
module tws_slave #(
  parameter int RX_DEPTH_P = tws_pkg::RX_DEPTH
) (
  clk,
  arst_n,
  scl_i,
  sda_i,
  sda_o,
  sda_oe,
  supply_ok_i,
  sel_i,
  write_busy,
  rx_data,
  rx_valid,
  rx_ready,
  tx_data,
  tx_valid,
  tx_ready,
  write_launch,
  start_seen,
  stop_seen,
  read_mode,
  addressed,
  standby,
  bus_idle
);
  import tws_pkg::*;

  input wire logic clk;
  input wire logic arst_n;
  input wire logic scl_i;
  input wire logic sda_i;
  output logic sda_o;
  output logic sda_oe;
  input wire logic supply_ok_i;
  input wire logic [tws_pkg::SEL_W-1:0] sel_i;
  input wire logic write_busy;
  output logic [tws_pkg::BYTE_W-1:0] rx_data;
  output logic rx_valid;
  input wire logic rx_ready;
  input wire logic [tws_pkg::BYTE_W-1:0] tx_data;
  input wire logic tx_valid;
  output logic tx_ready;
  output logic write_launch;
  output logic start_seen;
  output logic stop_seen;
  output logic read_mode;
  output logic addressed;
  output logic standby;
  output logic bus_idle;

  typedef struct packed {
    tws_phase_t phase;
    logic [CNT_W-1:0] cnt;
    logic [BYTE_W-1:0] shift;
    logic rnw;
    logic hit;
    logic nack;
    logic got_data;
    logic oe;
    logic scl_prev;
    logic sda_prev;
    logic launch;
    logic start_p;
    logic stop_p;
    logic idle;
  } tws_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release.
  logic [1:0] rst_q;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  assign rst_n = rst_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Pin conditioning.
  tws_pins_t pins_raw;
  tws_pins_t pins;

  assign pins_raw = '{scl: scl_i, sda: sda_i, por_ok: supply_ok_i, sel: sel_i};

  tws_pin_filter #(
    .W(PIN_W),
    .RST_VAL(PINS_RST)
  ) u_pins (
    .clk(clk),
    .rst_n(rst_n),
    .pin_i(pins_raw),
    .level_o(pins)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Received bytes wait here, so a slow consumer leaves bytes unacknowledged once the buffer is full.
  tws_byte_t rx_push;
  logic rx_in_ready;

  tws_fifo #(
    .W(BYTE_W),
    .DEPTH(RX_DEPTH_P)
  ) u_rx_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(rx_push.valid),
    .in_ready(rx_in_ready),
    .in_data(rx_push.data),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode, used at the end of every address byte.
  function automatic logic addr_match(input logic [BYTE_W-1:0] b,
                                      input logic [SEL_W-1:0] sel,
                                      input logic busy);
    addr_match = (b[ID_MSB:ID_LSB] == DEV_TYPE_ID) &&
                 (b[SEL_MSB:SEL_LSB] == sel) && !busy;
  endfunction : addr_match

  ////////////////////////////////////////////////////////////////////////////////
  // Protocol engine.
  tws_state_t s_q;
  tws_state_t s_d;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic tx_pop;

  assign scl_rise = pins.scl & ~s_q.scl_prev;
  assign scl_fall = ~pins.scl & s_q.scl_prev;
  assign start_cond = s_q.scl_prev & pins.scl & s_q.sda_prev & ~pins.sda;
  assign stop_cond = s_q.scl_prev & pins.scl & ~s_q.sda_prev & pins.sda;

  always_comb begin
    s_d = s_q;
    rx_push = '{data: s_q.shift, valid: 1'b0};
    tx_pop = 1'b0;
    s_d.scl_prev = pins.scl;
    s_d.sda_prev = pins.sda;
    s_d.launch = 1'b0;
    s_d.start_p = 1'b0;
    s_d.stop_p = 1'b0;
    s_d.idle = pins.scl & pins.sda;
    if (!pins.por_ok) begin
      s_d.phase = PH_POR;
      s_d.cnt = '0;
      s_d.oe = 1'b0;
      s_d.hit = 1'b0;
      s_d.got_data = 1'b0;
    end else if (s_q.phase == PH_POR) begin
      s_d.phase = PH_IDLE;
    end else if (start_cond) begin
      s_d.phase = PH_ADDR;
      // The clock fall that closes a Start carries no bit, so the count starts one below zero.
      s_d.cnt = '1;
      s_d.oe = 1'b0;
      s_d.hit = 1'b0;
      s_d.nack = 1'b0;
      s_d.got_data = 1'b0;
      s_d.start_p = 1'b1;
    end else if (stop_cond) begin
      s_d.launch = (s_q.phase == PH_WRITE) && s_q.got_data;
      s_d.phase = PH_IDLE;
      s_d.cnt = '0;
      s_d.oe = 1'b0;
      s_d.hit = 1'b0;
      s_d.got_data = 1'b0;
      s_d.stop_p = 1'b1;
    end else if (s_q.phase == PH_ADDR || s_q.phase == PH_WRITE || s_q.phase == PH_READ) begin
      if (scl_rise) begin
        if (s_q.cnt != BIT_ACK) begin
          if (s_q.phase != PH_READ) begin
            s_d.shift = {s_q.shift[BYTE_W-2:0], pins.sda};
          end
        end else if (s_q.phase == PH_READ) begin
          s_d.nack = pins.sda;
        end
      end else if (scl_fall) begin
        case (s_q.cnt)
          BIT_LAST: begin
            s_d.cnt = BIT_ACK;
            case (s_q.phase)
              PH_ADDR: begin
                s_d.hit = addr_match(s_q.shift, pins.sel, write_busy);
                s_d.rnw = s_q.shift[RNW_BIT];
                s_d.oe = s_d.hit;
              end
              PH_WRITE: begin
                rx_push.valid = rx_in_ready;
                s_d.got_data = s_q.got_data | rx_in_ready;
                s_d.oe = rx_in_ready;
              end
              default: begin
                s_d.oe = 1'b0;
              end
            endcase
          end
          BIT_ACK: begin
            s_d.cnt = '0;
            s_d.oe = 1'b0;
            case (s_q.phase)
              PH_ADDR: begin
                if (!s_q.hit) begin
                  s_d.phase = PH_IGNORE;
                end else if (s_q.rnw) begin
                  s_d.phase = PH_READ;
                  tx_pop = tx_valid;
                  s_d.shift = tx_valid ? tx_data : TX_IDLE_BYTE;
                  s_d.oe = ~s_d.shift[BYTE_W-1];
                end else begin
                  s_d.phase = PH_WRITE;
                end
              end
              PH_READ: begin
                if (s_q.nack) begin
                  s_d.phase = PH_IGNORE;
                end else begin
                  tx_pop = tx_valid;
                  s_d.shift = tx_valid ? tx_data : TX_IDLE_BYTE;
                  s_d.oe = ~s_d.shift[BYTE_W-1];
                end
              end
              default: begin
                s_d.phase = s_q.phase;
              end
            endcase
          end
          default: begin
            s_d.cnt = s_q.cnt + 1'b1;
            if (s_q.phase == PH_READ) begin
              s_d.shift = {s_q.shift[BYTE_W-2:0], 1'b1};
              s_d.oe = ~s_q.shift[BYTE_W-2];
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{phase: PH_POR, cnt: '0, shift: '0, rnw: 1'b0, hit: 1'b0, nack: 1'b0,
               got_data: 1'b0, oe: 1'b0, scl_prev: 1'b1, sda_prev: 1'b1,
               launch: 1'b0, start_p: 1'b0, stop_p: 1'b0, idle: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  // pull low only
  assign sda_o = 1'b0;
  assign sda_oe = s_q.oe;
  assign tx_ready = tx_pop;
  assign write_launch = s_q.launch;
  assign start_seen = s_q.start_p;
  assign stop_seen = s_q.stop_p;
  assign read_mode = (s_q.phase == PH_READ);
  assign addressed = s_q.hit;
  // Standby also waits for the internal write cycle, which holds the device awake.
  assign standby = (s_q.phase == PH_IDLE) && !write_busy;
  assign bus_idle = s_q.idle;

endmodule : tws_slave

// [bench/tws_chk.sv]
// Purpose: Port-level checks of the two-wire slave.
// Assumes: A pin level held six clocks or more is an event the filter sees.
// Notes: Event windows leave slack for the three-stage input filter.
`timescale 1ns/1ps
module tws_chk (
  clk,
  arst_n,
  scl_i,
  sda_i,
  sda_o,
  sda_oe,
  supply_ok_i,
  write_busy,
  tx_ready,
  write_launch,
  start_seen,
  stop_seen,
  standby,
  bus_idle
);
  input wire logic clk, arst_n, scl_i, sda_i, sda_o, sda_oe, supply_ok_i;
  input wire logic write_busy, tx_ready, write_launch, start_seen, stop_seen;
  input wire logic standby, bus_idle;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  AST_OPEN_DRAIN: assert property (sda_o == 1'h0)
    else $error("data line driven high");
  AST_POR_QUIET: assert property (!supply_ok_i [*7] |-> !sda_oe && !standby)
    else $error("active without supply");
  AST_IDLE_HI: assert property ((scl_i && sda_i) [*7] |-> bus_idle)
    else $error("idle bus not flagged");
  AST_IDLE_LO: assert property (!sda_i [*7] |-> !bus_idle)
    else $error("busy bus flagged idle");
  AST_START: assert property ((supply_ok_i && scl_i && sda_i) [*6] ##1
    (scl_i && !sda_i) [*3] |-> ##[0:6] start_seen) else $error("start missed");
  AST_STOP: assert property ((supply_ok_i && scl_i && !sda_i) [*6] ##1
    (scl_i && sda_i) [*3] |-> ##[0:6] stop_seen) else $error("stop missed");
  AST_STOP_REST: assert property (supply_ok_i && stop_seen && !write_launch
    && !write_busy |-> ##[0:3] standby) else $error("no standby after stop");
  AST_LAUNCH: assert property (write_launch |-> stop_seen)
    else $error("launch without stop");
  AST_OE_EDGE: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("drive changed with clock high");
  AST_ACK_HOLD: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("low drive too short");
  AST_TX_EDGE: assert property (tx_ready |-> !scl_i ##1 !tx_ready)
    else $error("byte load off the low phase");
  cover property (write_launch);
  cover property (tx_ready);
  cover property (start_seen ##[1:200] start_seen);
endmodule : tws_chk

bind tws_slave tws_chk u_chk (.clk(clk), .arst_n(arst_n), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .supply_ok_i(supply_ok_i), .write_busy(write_busy),
  .tx_ready(tx_ready), .write_launch(write_launch), .start_seen(start_seen),
  .stop_seen(stop_seen), .standby(standby), .bus_idle(bus_idle));

// [bench/tws_master.sv]
// Purpose: Behavioural bus master for the serial clock and data line.
// Assumes: Tasks are called at falling clk edges.
// Notes: A bit is six clk low and six high, so the filtered edges settle in each phase.
`timescale 1ns/1ps
module tws_master (
  clk,
  sda,
  scl,
  sda_lo
);
  input wire logic clk;
  input wire logic sda;
  output logic scl;
  output logic sda_lo;
  initial scl = 1'h1;
  initial sda_lo = 1'h0;
  ////////////////////////////////////////
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold
  task automatic start();
    sda_lo = 1'h0;
    hold(4);
    scl = 1'h1;
    hold(6);
    sda_lo = 1'h1;
    hold(6);
    scl = 1'h0;
    hold(2);
  endtask : start
  task automatic stop();
    sda_lo = 1'h1;
    hold(4);
    scl = 1'h1;
    hold(6);
    sda_lo = 1'h0;
    hold(6);
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    sda_lo = !b;
    hold(4);
    scl = 1'h1;
    hold(3);
    r = sda;
    hold(3);
    scl = 1'h0;
    hold(2);
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, input logic ma, output logic [7:0] q,
    output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ma, a);
  endtask : xfer
endmodule : tws_master

// [bench/testbench.sv]
// Purpose: Self-checking bench for the two-wire slave.
// Assumes: One master model; supply, straps and write state are driven here.
// Notes: Serial clock period is 1.2 us; shorter phases would defeat the filter.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  import tws_pkg::*;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic scl, m_lo, sda_w, sda_o, sda_oe, rx_valid, tx_ready, launch, st_p, sp_p;
  logic read_mode, addressed, standby, bus_idle;
  logic supply_ok, busy, rx_ready, tx_valid;
  logic [SEL_W-1:0] sel;
  logic [BYTE_W-1:0] rx_data;
  logic [BYTE_W-1:0] txd [4] = '{8'hc3, 8'h80, 8'h00, 8'hff};
  logic [1:0] tx_idx = 2'h0;
  logic [BYTE_W-1:0] rxq [$];
  logic [12:0] rows [7] = '{{8'ha0, 3'h0, 1'h0, 1'h0}, {8'ha2, 3'h0, 1'h0, 1'h1},
    {8'hb0, 3'h0, 1'h0, 1'h1}, {8'hae, 3'h7, 1'h0, 1'h0}, {8'ha8, 3'h4, 1'h0, 1'h0},
    {8'ha0, 3'h0, 1'h1, 1'h1}, {8'h20, 3'h0, 1'h0, 1'h1}};
  int err_total = 0;
  int total_checks = 0;
  int n_start = 0;
  int n_launch = 0;
  always #50 clk = ~clk;
  assign sda_w = (sda_oe ? sda_o : 1'h1) & !m_lo;
  tws_slave #(.RX_DEPTH_P(RX_DEPTH)) dut (
    .clk(clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .supply_ok_i(supply_ok), .sel_i(sel), .write_busy(busy), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(txd[tx_idx]), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .write_launch(launch), .start_seen(st_p), .stop_seen(sp_p),
    .read_mode(read_mode), .addressed(addressed), .standby(standby), .bus_idle(bus_idle));
  tws_master m (.clk(clk), .sda(sda_w), .scl(scl), .sda_lo(m_lo));
  always @(posedge clk) begin
    n_start += (st_p === 1'h1);
    n_launch += (launch === 1'h1);
    if (rx_valid === 1'h1 && rx_ready === 1'h1) begin
      rxq.push_back(rx_data);
    end
    if (tx_ready === 1'h1) begin
      tx_idx <= tx_idx + 2'h1;
    end
  end
  ////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test();
  end
  initial begin
    logic [7:0] a, q;
    logic [2:0] s;
    logic b, e, r;
    int k, n;
    supply_ok = 1'h0;
    busy = 1'h0;
    rx_ready = 1'h0;
    sel = '0;
    tx_valid = 1'h1;
    repeat (4) @(negedge clk);
    arst_n = 1'h1;
    m.hold(20);
    m.start();
    m.xfer(8'ha0, 1'h1, q, r);
    `CHK("por_ack", 1'h1, r)
    `CHK("por_standby", 1'h0, standby)
    m.stop();
    supply_ok = 1'h1;
    m.hold(POWER_UP_SETTLE_CYC);
    `CHK("standby", 1'h1, standby)
    `CHK("bus_idle", 1'h1, bus_idle)
    k = n_start;
    foreach (rows[i]) begin
      {a, s, b, e} = rows[i];
      sel = s;
      busy = b;
      m.start();
      m.xfer(a, 1'h1, q, r);
      `CHK("addr_ack", e, r)
      `CHK("addr_hit", !e, addressed)
      m.stop();
      busy = 1'h0;
    end
    `CHK("starts", k + 7, n_start)
    m.start();
    m.xfer(8'ha0, 1'h1, q, r);
    m.xfer(8'h5a, 1'h1, q, r);
    `CHK("wr_ack1", 1'h0, r)
    m.xfer(8'h96, 1'h1, q, r);
    `CHK("wr_ack2", 1'h0, r)
    m.xfer(8'h3c, 1'h1, q, r);
    `CHK("full_nack", 1'h1, r)
    k = n_start;
    m.start();
    m.xfer(8'ha0, 1'h1, q, r);
    `CHK("rep_ack", 1'h0, r)
    `CHK("rep_start", k + 1, n_start)
    `CHK("rep_hit", 1'h1, addressed)
    `CHK("rep_launch", 0, n_launch)
    rx_ready = 1'h1;
    m.hold(4);
    rx_ready = 1'h0;
    `CHK("rx_count", 2, rxq.size())
    `CHK("rx0", 8'h5a, rxq[0])
    `CHK("rx1", 8'h96, rxq[1])
    m.xfer(8'h11, 1'h1, q, r);
    `CHK("wr_ack3", 1'h0, r)
    m.stop();
    `CHK("launch", 1, n_launch)
    `CHK("rx_hold", 1'h1, rx_valid)
    busy = 1'h1;
    m.hold(3);
    `CHK("busy_sb", 1'h0, standby)
    busy = 1'h0;
    m.hold(3);
    `CHK("done_sb", 1'h1, standby)
    m.start();
    m.xfer(8'ha1, 1'h1, q, r);
    m.xfer(8'hff, 1'h0, q, r);
    `CHK("rd0", 8'hc3, q)
    `CHK("rd_mode", 1'h1, read_mode)
    m.xfer(8'hff, 1'h1, q, r);
    `CHK("rd1", 8'h80, q)
    m.hold(4);
    `CHK("nack_rel", 1'h0, sda_oe)
    `CHK("nack_mode", 1'h0, read_mode)
    m.stop();
    m.start();
    m.xfer(8'ha1, 1'h1, q, r);
    for (int i = 0; i < 3; i++) begin
      m.bit_io(1'h1, r);
    end
    `CHK("held_low", 1'h0, r)
    n = 0;
    while (r !== 1'h1 && n < 9) begin
      m.bit_io(1'h1, r);
      n++;
    end
    `CHK("dummies", 6, n)
    m.start();
    m.xfer(8'ha0, 1'h1, q, r);
    `CHK("recover_ack", 1'h0, r)
    m.stop();
    tx_valid = 1'h0;
    k = tx_idx;
    m.start();
    m.xfer(8'ha1, 1'h1, q, r);
    m.xfer(8'hff, 1'h1, q, r);
    `CHK("empty_ff", 8'hff, q)
    `CHK("empty_idx", k, tx_idx)
    m.stop();
    tx_valid = 1'h1;
    k = n_start;
    m.bit_io(1'h1, r);
    m.xfer(8'ha0, 1'h1, q, r);
    `CHK("nostart_ack", 1'h1, r)
    `CHK("nostart_cnt", k, n_start)
    m.stop();
    arst_n = 1'h0;
    m.hold(2);
    `CHK("rst_oe", 1'h0, sda_oe)
    `CHK("rst_sb", 1'h0, standby)
    arst_n = 1'h1;
    m.hold(20);
    `CHK("rst_sb2", 1'h1, standby)
    finish_test();
  end
endmodule : testbench
